// ---- src/tcc_capcmp_chan.sv ----
// One capture/compare register with its equality detector.
// Assumes capture triggers are already gated by the run state.
`timescale 1ns/100ps
module tcc_capcmp_chan
   import tcc_pkg::*;
#(
   parameter int unsigned W = TCC_DATA_W
)(
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   // Software write
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wdata_i,
   // Mode and trigger
   input  wire logic         capture_mode_i,
   input  wire logic         cap_trig_i,
   input  wire logic [W-1:0] count_i,
   // Results
   output logic      [W-1:0] value_o,
   output logic              hit_o
);

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         value_o <= W'(TCC_CC_RST);
      end else if (wr_i) begin
         value_o <= wdata_i;
      end else if (capture_mode_i && cap_trig_i) begin
         value_o <= count_i;
      end
   end

   assign hit_o = ~capture_mode_i & (value_o == count_i);

   AST_CC_KEEP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (!capture_mode_i && !wr_i) |=> $stable(value_o))
      else $error("compare reference changed without a write");

   AST_CC_HOLD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      (!cap_trig_i && !wr_i) |=> $stable(value_o))
      else $error("held value lost without trigger or write");

endmodule : tcc_capcmp_chan

// ---- src/tcc_core.sv ----
// Core of the 16-bit timer/event counter with two capture/compare registers.
// Assumes count_tick_i is a one-cycle pulse from a prescaler on mclk_i,
// and the trigger pins are asynchronous to mclk_i.
//
// Summary of operation
// - Timer count is sixteen bits and read only; writes leave it alone.
// - Count advances by one on each count tick while running.
// - Count reads live while running and reads 0000H when stopped.
// - Count is 0000H after reset and whenever run mode becomes 00.
// - Clear-on-pin mode: valid pin A edge clears the count, counting restarts.
// - Clear-on-match mode: count clears when it equals register A.
// - One-shot mode: trigger write or pin A valid edge clears the count.
// - Reading the count never loads register B.
// - Each capture/compare register works as capture or compare, by control.
// - Both capture/compare registers are accessed as whole 16-bit words.
// - Both capture/compare registers reset to 0000H.
// - Register A compares continuously; equality raises match pulse A.
// - Register A in compare mode ignores capture triggers.
// - Register A captures on pin A opposite edge or pin B valid edge.
// - Capture coinciding with stop may hold any value.
// - A captured value stays until rewritten or reset.
// - Register B compares continuously; equality raises match pulse B.
// - Register B captures the count on pin A valid edge.
// - Counting starts when run mode leaves 00 and stops on 00.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module tcc_core
   import tcc_pkg::*;
#(
   parameter int unsigned W = TCC_DATA_W
)(
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         resetn_i,
   // Register port
   input  wire tcc_bus_req_t bus_req_i,
   output logic      [15:0]  rdata_o,
   // Count clock from prescaler
   input  wire logic         count_tick_i,
   // Trigger pins
   input  wire logic         trigger_pin_a_i,
   input  wire logic         trigger_pin_b_i,
   // Match pulses
   output logic              match_irq_a_o,
   output logic              match_irq_b_o
);

   tcc_ctrl_t      ctrl_q;
   tcc_ctrl_t      ctrl_d;
   logic [W-1:0]   count_q;
   logic [W-1:0]   count_d;
   logic [W-1:0]   cc_a;
   logic [W-1:0]   cc_b;
   logic           hit_a;
   logic           hit_b;
   logic [1:0]     rise;
   logic [1:0]     fall;
   logic [1:0]     pins;

   // Edge of a pin by selection; NONE gives no edge
   function automatic logic tcc_pick(input logic r, input logic f,
                                     input logic [1:0] sel);
      logic res;
      res = 1'b0;
      case (sel)
         TCC_EDGE_FALL: res = f;
         TCC_EDGE_RISE: res = r;
         TCC_EDGE_BOTH: res = r | f;
         default:       res = 1'b0;
      endcase
      return res;
   endfunction : tcc_pick

   // Address decode
   wire sel_count = (bus_req_i.addr == TCC_ADDR_COUNT);
   wire sel_cca   = (bus_req_i.addr == TCC_ADDR_CCA);
   wire sel_ccb   = (bus_req_i.addr == TCC_ADDR_CCB);
   wire sel_ctrl  = (bus_req_i.addr == TCC_ADDR_CTRL);
   wire wr_cca    = bus_req_i.wr & sel_cca;
   wire wr_ccb    = bus_req_i.wr & sel_ccb;
   wire wr_ctrl   = bus_req_i.wr & sel_ctrl;
   wire rd_count  = bus_req_i.rd & sel_count;

   // Run state
   wire running   = (ctrl_q.run_mode != TCC_RUN_STOP);
   wire mode_pin  = (ctrl_q.run_mode == TCC_RUN_CLR_PIN);
   wire mode_mat  = (ctrl_q.run_mode == TCC_RUN_CLR_MATCH);
   wire [1:0] wr_run = bus_req_i.wdata[1:0];
   wire stop_wr   = wr_ctrl & (wr_run == TCC_RUN_STOP);
   wire os_fire   = wr_ctrl & bus_req_i.wdata[3] & ctrl_q.one_shot_mode;

   // Valid and opposite edges
   wire valid_a   = tcc_pick(rise[0], fall[0], ctrl_q.edge_a);
   wire opp_a     = tcc_pick(fall[0], rise[0], ctrl_q.edge_a);
   wire valid_b   = tcc_pick(rise[1], fall[1], ctrl_q.edge_b);

   // triggers gated by the old run state
   wire trig_a    = running & (ctrl_q.a_src_pin_b ? valid_b : opp_a);
   // register B triggered by pin A valid edge
   wire trig_b    = running & valid_a;

   // clear on pin A valid edge
   wire clr_pin   = mode_pin & valid_a;
   // clear on match with register A
   wire clr_match = mode_mat & count_tick_i & (count_q == cc_a);
   wire clr_os    = running & ctrl_q.one_shot_mode & (os_fire | valid_a);
   wire clr_any   = clr_pin | clr_match | clr_os;

   // match pulse A on tick at equality
   wire irq_a_d   = running & count_tick_i & hit_a;
   // match pulse B on tick at equality
   wire irq_b_d   = running & count_tick_i & hit_b;

   wire [15:0] count_rd = running ? 16'(count_q) : TCC_COUNT_RST;
   wire [15:0] rd_mux   = sel_count ? count_rd :
                          sel_cca   ? 16'(cc_a) :
                          sel_ccb   ? 16'(cc_b) :
                          sel_ctrl  ? 16'(ctrl_q) : TCC_RDATA_IDLE;

   assign pins = {trigger_pin_b_i, trigger_pin_a_i};

   // One synchroniser per trigger pin
   for (genvar g = 0; g < 2; g++) begin : g_pin
      tcc_edge_sync u_sync (
         .mclk_i   (mclk_i),
         .resetn_i (resetn_i),
         .pin_i    (pins[g]),
         .rise_o   (rise[g]),
         .fall_o   (fall[g])
      );
   end

   tcc_capcmp_chan #(.W(W)) u_cca (
      .mclk_i         (mclk_i),
      .resetn_i       (resetn_i),
      .wr_i           (wr_cca),
      .wdata_i        (bus_req_i.wdata[W-1:0]),
      .capture_mode_i (ctrl_q.cap_a),
      .cap_trig_i     (trig_a),
      .count_i        (count_q),
      .value_o        (cc_a),
      .hit_o          (hit_a)
   );

   // no load path from a count read
   tcc_capcmp_chan #(.W(W)) u_ccb (
      .mclk_i         (mclk_i),
      .resetn_i       (resetn_i),
      .wr_i           (wr_ccb),
      .wdata_i        (bus_req_i.wdata[W-1:0]),
      .capture_mode_i (ctrl_q.cap_b),
      .cap_trig_i     (trig_b),
      .count_i        (count_q),
      .value_o        (cc_b),
      .hit_o          (hit_b)
   );

   // Trigger bit is a pulse, never stored
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = tcc_ctrl_t'(bus_req_i.wdata);
         ctrl_d.one_shot_trig = 1'b0;
         ctrl_d.rsvd = '0;
      end
   end

   // no software path into the count
   always_comb begin
      count_d = count_q;
      if (!running || stop_wr) begin
         count_d = W'(TCC_COUNT_RST);
      end else if (clr_any) begin
         count_d = '0;
      end else if (count_tick_i) begin
         count_d = count_q + W'(1);
      end
   end

   // start and stop follow the run field
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_q  <= tcc_ctrl_t'(TCC_CTRL_RST);
         count_q <= W'(TCC_COUNT_RST);
      end else begin
         ctrl_q  <= ctrl_d;
         count_q <= count_d;
      end
   end

   // whole-word reads, data in next cycle only
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o       <= TCC_RDATA_IDLE;
         match_irq_a_o <= 1'b0;
         match_irq_b_o <= 1'b0;
      end else begin
         rdata_o       <= bus_req_i.rd ? rd_mux : TCC_RDATA_IDLE;
         match_irq_a_o <= irq_a_d;
         match_irq_b_o <= irq_b_d;
      end
   end

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_stopped;
      ctrl_q.run_mode == TCC_RUN_STOP;
   endsequence

   sequence s_start_tick;
      wr_ctrl && wr_run != TCC_RUN_STOP ##1 count_tick_i && !clr_any && !bus_req_i.wr;
   endsequence

   AST_COUNT_STEP: assert property (
      (running && count_tick_i && !clr_any && !stop_wr)
      |=> count_q == $past(count_q) + W'(1))
      else $error("count did not advance by one");

   AST_COUNT_HOLD: assert property (
      (running && !count_tick_i && !clr_any && !stop_wr)
      |=> $stable(count_q))
      else $error("count moved without a tick");

   AST_READ_STOP: assert property (
      (rd_count && !running) |=> rdata_o == 16'h0000)
      else $error("stopped count read non-zero");

   AST_READ_LIVE: assert property (
      (rd_count && running) |=> rdata_o == 16'($past(count_q)))
      else $error("running count read wrong");

   AST_STOP_ZERO: assert property (
      s_stopped |-> count_q == '0)
      else $error("count not zero while stopped");

   AST_PIN_CLEAR: assert property (
      (mode_pin && valid_a && !stop_wr && !wr_ctrl) |=> count_q == '0)
      else $error("pin edge did not clear count");

   AST_MATCH_CLEAR: assert property (
      (clr_match && !wr_ctrl) |=> count_q == '0 ##1 count_q <= W'(1))
      else $error("match did not clear count");

   AST_OS_CLEAR: assert property (
      (os_fire && running && !stop_wr) |=> count_q == '0)
      else $error("one-shot trigger did not clear count");

   AST_READ_NO_LOAD: assert property (
      (rd_count && !trig_b && !wr_ccb) |=> $stable(cc_b))
      else $error("count read disturbed register B");

   AST_READ_CCA: assert property (
      (bus_req_i.rd && sel_cca) |=> rdata_o == 16'($past(cc_a)))
      else $error("register A read wrong");

   AST_IRQ_A: assert property (
      match_irq_a_o |-> $past(count_q == cc_a && !ctrl_q.cap_a && count_tick_i))
      else $error("match pulse A without equality");

   AST_IRQ_B: assert property (
      (running && count_tick_i && !ctrl_q.cap_b && count_q == cc_b)
      |=> match_irq_b_o)
      else $error("missing match pulse B");

   AST_CAP_A: assert property (
      (ctrl_q.cap_a && trig_a && !wr_cca) |=> cc_a == $past(count_q))
      else $error("register A failed to capture");

   AST_CAP_B: assert property (
      (ctrl_q.cap_b && trig_b && !wr_ccb) |=> cc_b == $past(count_q))
      else $error("register B failed to capture");

   AST_START: assert property (
      s_stopped ##0 s_start_tick |=> count_q == W'(1))
      else $error("counter did not start");

   // Port checks: read data stand one cycle, then drop to idle
   AST_READ_CCB: assert property (
      (bus_req_i.rd && sel_ccb) |=> rdata_o == 16'($past(cc_b)))
      else $error("register B read wrong");

   AST_READ_CTRL: assert property (
      (bus_req_i.rd && sel_ctrl) |=> rdata_o == 16'($past(ctrl_q)))
      else $error("control word read wrong");

   AST_READ_UNMAPPED: assert property (
      (bus_req_i.rd && !sel_count && !sel_cca && !sel_ccb && !sel_ctrl)
      |=> rdata_o == TCC_RDATA_IDLE)
      else $error("unmapped read not zero");

   AST_READ_IDLE: assert property (
      !bus_req_i.rd |=> rdata_o == TCC_RDATA_IDLE)
      else $error("read data outlived its cycle");

   AST_WRITE_CCA: assert property (
      wr_cca |=> cc_a == $past(bus_req_i.wdata[W-1:0]))
      else $error("register A write lost");

   AST_WRITE_CCB: assert property (
      wr_ccb |=> cc_b == $past(bus_req_i.wdata[W-1:0]))
      else $error("register B write lost");

   AST_COUNT_NO_WRITE: assert property (
      (bus_req_i.wr && sel_count && !count_tick_i && !clr_any)
      |=> $stable(count_q))
      else $error("count write reached the counter");

   AST_STOP_WR_ZERO: assert property (
      stop_wr |=> count_q == '0)
      else $error("stop write did not clear count");

   AST_TRIG_NOT_HELD: assert property (
      wr_ctrl |=> !ctrl_q.one_shot_trig && ctrl_q.rsvd == '0)
      else $error("trigger or reserved bits stored");

   AST_IRQ_A_RAISE: assert property (
      (running && count_tick_i && !ctrl_q.cap_a && count_q == cc_a)
      |=> match_irq_a_o)
      else $error("missing match pulse A");

   AST_IRQ_B_SRC: assert property (
      match_irq_b_o
      |-> $past(running && count_tick_i && !ctrl_q.cap_b && count_q == cc_b))
      else $error("match pulse B without equality");

   AST_CCB_CMP_KEEP: assert property (
      (!ctrl_q.cap_b && !wr_ccb) |=> $stable(cc_b))
      else $error("compare reference B changed without a write");

   // Old run state gates capture, so a trigger with the stop write still captures; none once stopped
   AST_STOP_NO_CAPTURE: assert property (
      (!running && !wr_cca && !wr_ccb)
      |=> $stable(cc_a) && $stable(cc_b))
      else $error("capture while stopped");

   AST_NO_IRQ_STOPPED: assert property (
      !running |=> !match_irq_a_o && !match_irq_b_o)
      else $error("match pulse while stopped");

endmodule : tcc_core

// ---- src/tcc_edge_sync.sv ----
// Trigger pin synchroniser with registered rise and fall pulses.
// Assumes an asynchronous pin; pulses are one clock long.
`timescale 1ns/100ps
module tcc_edge_sync
   import tcc_pkg::*;
(
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic resetn_i,
   // Pin and edges
   input  wire logic pin_i,
   output logic      rise_o,
   output logic      fall_o
);

   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // Only sync2_q reads the first stage
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
         rise_o  <= 1'b0;
         fall_o  <= 1'b0;
      end else begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
         rise_o  <= sync2_q & ~prev_q;
         fall_o  <= ~sync2_q & prev_q;
      end
   end

endmodule : tcc_edge_sync

// ---- src/tcc_pkg.sv ----
// Shared constants and types of the 16-bit timer capture/compare core.
// Assumes one clock domain and the plain register port of the core.
package tcc_pkg;

   localparam int unsigned TCC_DATA_W = 16;
   localparam int unsigned TCC_ADDR_W = 16;

   // Register addresses on the plain port
   localparam logic [15:0] TCC_ADDR_COUNT = 16'hFF10;
   localparam logic [15:0] TCC_ADDR_CCA   = 16'hFF12;
   localparam logic [15:0] TCC_ADDR_CCB   = 16'hFF14;
   localparam logic [15:0] TCC_ADDR_CTRL  = 16'hFF16;

   // Reset values
   localparam logic [15:0] TCC_COUNT_RST = 16'h0000;
   localparam logic [15:0] TCC_CC_RST    = 16'h0000;
   localparam logic [15:0] TCC_CTRL_RST  = 16'h0000;
   localparam logic [15:0] TCC_RDATA_IDLE = 16'h0000;

   // Run-mode field values
   typedef enum logic [1:0] {
      TCC_RUN_STOP      = 2'b00,
      TCC_RUN_FREE      = 2'b01,
      TCC_RUN_CLR_PIN   = 2'b10,
      TCC_RUN_CLR_MATCH = 2'b11
   } tcc_run_t;

   // Valid-edge selection of a trigger pin
   typedef enum logic [1:0] {
      TCC_EDGE_FALL = 2'b00,
      TCC_EDGE_RISE = 2'b01,
      TCC_EDGE_BOTH = 2'b10,
      TCC_EDGE_NONE = 2'b11
   } tcc_edge_t;

   // Control word layout, most significant field first
   typedef struct packed {
      logic [4:0] rsvd;
      logic [1:0] edge_b;
      logic [1:0] edge_a;
      logic       a_src_pin_b;
      logic       cap_b;
      logic       cap_a;
      logic       one_shot_trig;
      logic       one_shot_mode;
      logic [1:0] run_mode;
   } tcc_ctrl_t;

   // Register port request
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } tcc_bus_req_t;

endpackage : tcc_pkg

// ---- verification/tb_top.sv ----
// Bench top: register-port tests of the timer capture/compare core.
// Assumes a 50 MHz clock and the pin model on both trigger pins.
`timescale 1ns/100ps
module tb_top;
   import tcc_pkg::*;

   logic         mclk_i      = 1'b0;
   logic         resetn_i    = 1'b0;
   tcc_bus_req_t bus_req     = '0;
   logic         tick        = 1'b0;
   logic [15:0]  rdata;
   logic         pin_a;
   logic         pin_b;
   logic         irq_a;
   logic         irq_b;
   int           miscompares = 0;
   int           checks      = 0;
   int           n_irq_a     = 0;
   int           n_irq_b     = 0;

   always #10 mclk_i = ~mclk_i;

   tcc_core u_dut (
      .mclk_i          (mclk_i),
      .resetn_i        (resetn_i),
      .bus_req_i       (bus_req),
      .rdata_o         (rdata),
      .count_tick_i    (tick),
      .trigger_pin_a_i (pin_a),
      .trigger_pin_b_i (pin_b),
      .match_irq_a_o   (irq_a),
      .match_irq_b_o   (irq_b)
   );

   tcc_pin_model u_pins (
      .mclk_i  (mclk_i),
      .pin_a_o (pin_a),
      .pin_b_o (pin_b)
   );

   // Match pulses are one cycle long, so one count per pulse
   always @(posedge mclk_i) begin
      if (irq_a === 1'b1) n_irq_a++;
      if (irq_b === 1'b1) n_irq_b++;
   end

   task automatic end_of_test;
      if (miscompares == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [15:0] addr, input logic [15:0] data);
      @(posedge mclk_i);
      bus_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus_req.wr <= 1'b0;
      #1;
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp, input string what);
      @(posedge mclk_i);
      bus_req <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      bus_req.rd <= 1'b0;
      #1;
      check(what, exp, rdata);
   endtask : rd_chk

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge mclk_i);
         tick <= 1'b1;
         @(posedge mclk_i);
         tick <= 1'b0;
      end
      #1;
   endtask : ticks

   initial begin
      #400000;
      miscompares++;
      end_of_test();
   end

   initial begin
      int a0;
      int b0;
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      rd_chk(TCC_ADDR_COUNT, 16'h0000, "count");
      rd_chk(TCC_ADDR_CCA, 16'h0000, "reg_a");
      rd_chk(TCC_ADDR_CCB, 16'h0000, "reg_b");
      rd_chk(16'hFF18, 16'h0000, "unmapped");
      wr(TCC_ADDR_CCB, 16'hA5C3);
      rd_chk(TCC_ADDR_CCB, 16'hA5C3, "reg_b");
      wr(TCC_ADDR_COUNT, 16'h1234);
      wr(TCC_ADDR_CTRL, 16'h0001);
      ticks(5);
      rd_chk(TCC_ADDR_COUNT, 16'h0005, "count");
      rd_chk(TCC_ADDR_CCB, 16'hA5C3, "reg_b");
      wr(TCC_ADDR_CTRL, 16'h0000);
      rd_chk(TCC_ADDR_COUNT, 16'h0000, "count");
      wr(TCC_ADDR_CTRL, 16'h0001);
      rd_chk(TCC_ADDR_COUNT, 16'h0000, "count");
      ticks(1);
      rd_chk(TCC_ADDR_COUNT, 16'h0001, "count");
      // Compare and clear on match, written while stopped
      wr(TCC_ADDR_CTRL, 16'h0000);
      wr(TCC_ADDR_CCA, 16'h0003);
      wr(TCC_ADDR_CCB, 16'h0002);
      wr(TCC_ADDR_CTRL, 16'h0003);
      a0 = n_irq_a;
      b0 = n_irq_b;
      ticks(4);
      rd_chk(TCC_ADDR_COUNT, 16'h0000, "count");
      check("irq_a", 16'h0001, 16'(n_irq_a - a0));
      check("irq_b", 16'h0001, 16'(n_irq_b - b0));
      rd_chk(TCC_ADDR_CCA, 16'h0003, "reg_a");
      ticks(2);
      rd_chk(TCC_ADDR_COUNT, 16'h0002, "count");
      // Capture: A from pin B, B from pin A rise
      wr(TCC_ADDR_CTRL, 16'h0000);
      wr(TCC_ADDR_CTRL, 16'h02F1);
      rd_chk(TCC_ADDR_CTRL, 16'h02F1, "ctrl");
      ticks(4);
      u_pins.drive(1'b1, 1'b1);
      rd_chk(TCC_ADDR_CCA, 16'h0004, "reg_a");
      u_pins.drive(1'b0, 1'b1);
      rd_chk(TCC_ADDR_CCB, 16'h0004, "reg_b");
      ticks(2);
      u_pins.drive(1'b0, 1'b0);
      rd_chk(TCC_ADDR_CCA, 16'h0004, "reg_a");
      // Capture A on the edge opposite to pin A's valid edge
      wr(TCC_ADDR_CTRL, 16'h0000);
      wr(TCC_ADDR_CTRL, 16'h02B1);
      ticks(3);
      u_pins.drive(1'b0, 1'b1);
      ticks(2);
      u_pins.drive(1'b0, 1'b0);
      rd_chk(TCC_ADDR_CCA, 16'h0005, "reg_a");
      rd_chk(TCC_ADDR_CCB, 16'h0003, "reg_b");
      // Compare mode ignores triggers and keeps captured values
      wr(TCC_ADDR_CTRL, 16'h0000);
      wr(TCC_ADDR_CTRL, 16'h0241);
      u_pins.drive(1'b1, 1'b0);
      ticks(2);
      u_pins.drive(1'b1, 1'b1);
      u_pins.drive(1'b0, 1'b1);
      u_pins.drive(1'b0, 1'b0);
      rd_chk(TCC_ADDR_CCA, 16'h0005, "reg_a");
      rd_chk(TCC_ADDR_CCB, 16'h0003, "reg_b");
      wr(TCC_ADDR_CTRL, 16'h0000);
      wr(TCC_ADDR_CCA, 16'h0010);
      // Clear and restart on pin A rise
      u_pins.drive(1'b0, 1'b0);
      wr(TCC_ADDR_CTRL, 16'h0082);
      ticks(5);
      rd_chk(TCC_ADDR_COUNT, 16'h0005, "count");
      u_pins.drive(1'b0, 1'b1);
      rd_chk(TCC_ADDR_COUNT, 16'h0000, "count");
      ticks(2);
      rd_chk(TCC_ADDR_COUNT, 16'h0002, "count");
      // One-shot software trigger
      wr(TCC_ADDR_CTRL, 16'h0000);
      // Tick right behind the start write
      @(posedge mclk_i);
      bus_req <= '{addr: TCC_ADDR_CTRL, wdata: 16'h0005, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      bus_req.wr <= 1'b0;
      tick       <= 1'b1;
      @(posedge mclk_i);
      tick       <= 1'b0;
      ticks(2);
      rd_chk(TCC_ADDR_COUNT, 16'h0003, "count");
      wr(TCC_ADDR_CTRL, 16'h000D);
      rd_chk(TCC_ADDR_COUNT, 16'h0000, "count");
      ticks(1);
      rd_chk(TCC_ADDR_COUNT, 16'h0001, "count");
      rd_chk(TCC_ADDR_CTRL, 16'h0005, "ctrl");
      end_of_test();
   end

endmodule : tb_top

// ---- verification/tcc_pin_model.sv ----
// Pin-side model: drives the two external trigger pins of the core.
// Assumes the bench commands every edge; pins idle low.
`timescale 1ns/100ps
module tcc_pin_model (
   // Clock
   input  wire logic mclk_i,
   // Trigger pins
   output logic      pin_a_o,
   output logic      pin_b_o
);

   initial begin
      pin_a_o = 1'b0;
      pin_b_o = 1'b0;
   end

   // trigger edge source
   // Level held well past the synchroniser and edge stage latency
   task automatic drive(input logic sel_b, input logic level);
      @(posedge mclk_i);
      if (sel_b) begin
         pin_b_o <= level;
      end else begin
         pin_a_o <= level;
      end
      repeat (8) @(posedge mclk_i);
      #1;
   endtask : drive

endmodule : tcc_pin_model
